// *** hdl/irc_pkg.sv ***
package irc_pkg;

    // ==========================================================
    // widths and presets
    localparam int          BYTE_W        = 8;
    localparam int          WORD_W        = 16;
    localparam logic [7:0]  BYTE_PRESET_0 = 8'h00;
    localparam logic [7:0]  BYTE_PRESET_1 = 8'hFF;
    localparam logic [15:0] WORD_PRESET_0 = 16'h0000;
    localparam logic [15:0] WORD_PRESET_1 = 16'hFFFF;

    // ==========================================================
    // status word bit positions
    localparam int ST_FLAG_POS  = 0;
    localparam int ST_EN_POS    = 1;
    localparam int ST_INST_POS  = 2;
    localparam int ST_INST_W    = 3;

    // ==========================================================
    // trigger pulse timing
    localparam int CLK_MHZ       = 200;
    localparam int PULSE_MIN_US  = 2;
    localparam int PULSE_MAX_US  = 12;
    localparam int PULSE_MIN_CYC = PULSE_MIN_US * CLK_MHZ;
    localparam int PULSE_MAX_CYC = PULSE_MAX_US * CLK_MHZ;
    localparam int PULSE_CNT_W   = 12;

    // ==========================================================
    // load strobes travelling together
    typedef struct packed {
        logic word_byte;  // load whole 8-bit register
        logic word_lo;    // load low byte of 16-bit register
        logic word_hi;    // load high byte of 16-bit register
    } irc_load_type;

    // read selects travelling together
    typedef struct packed {
        logic rd_byte;    // drive 8-bit register on bus
        logic rd_word;    // drive 16-bit register on bus
        logic rd_status;  // drive status word on bus
    } irc_read_type;

    typedef enum logic [1:0] {
        IRC_IDLE  = 2'b00,
        IRC_PULSE = 2'b01
    } irc_trig_state_type;

endpackage

// *** hdl/irc_trigger.sv ***
`timescale 1ns/1ps
`default_nettype none

module irc_trigger (
    input  wire logic                          clk,        // system clock
    input  wire logic                          rst,        // async reset
    input  wire logic                          fire,       // one-cycle fire request
    input  wire logic [irc_pkg::PULSE_CNT_W-1:0] width_cyc, // pulse width in cycles
    input  wire logic                          neg_pol,    // 1 = negative-going
    output logic                               trig_out    // registered trigger pin
);

    // ==========================================================
    // one-shot state
    irc_pkg::irc_trig_state_type state_q;
    logic [irc_pkg::PULSE_CNT_W-1:0] cnt_q;

    // single pulse; refires ignored while active
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            state_q <= irc_pkg::IRC_IDLE;
            cnt_q   <= '0;
        end else begin
            case (state_q)
                irc_pkg::IRC_IDLE: begin
                    if (fire) begin
                        state_q <= irc_pkg::IRC_PULSE;
                        cnt_q   <= width_cyc - 1'b1;
                    end
                end
                irc_pkg::IRC_PULSE: begin
                    if (cnt_q == '0) begin
                        state_q <= irc_pkg::IRC_IDLE;
                    end else begin
                        cnt_q <= cnt_q - 1'b1;
                    end
                end
                default: begin
                    state_q <= irc_pkg::IRC_IDLE;
                    cnt_q   <= '0;
                end
            endcase
        end
    end

    // polarity applied at the output flop
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            trig_out <= 1'b0;
        end else begin
            trig_out <= neg_pol ^ ((state_q == irc_pkg::IRC_IDLE) ? fire
                        : (cnt_q != '0));
        end
    end

endmodule

`default_nettype wire

// *** hdl/irc_port.sv ***
// How it works
// - two output registers, 8 and 16 bits, load straight from the bus data lines.
// - a load strobe from the address selector captures bus data into its register.
// - the 8-bit register and each byte of the 16-bit register have their own strobe.
// - every register bit drives the instrument cable continuously.
// - the interrupt flag sets on the instrument ready edge, polarity chosen by a setting.
// - software sets the interrupt enable flag; both flags go out to interrupt control.
// - any register load strobe clears the interrupt flag unless a ready edge sets it in the same cycle.
// - reset always clears the interrupt flag and the interrupt enable flag.
// - a read select drives the register contents onto the bus data lines.
// - reset presets all register bits to zero, or to one when the preset setting is high.
// - a status read returns both flags and the instrument status inputs.
// - a selector command fires one trigger pulse of 2 to 12 us.
// - a setting picks a positive or negative going trigger pulse.
`timescale 1ns/1ps
`default_nettype none

module irc_port (
    input  wire logic                          clk,          // system clock
    input  wire logic                          rst,          // async reset, power-up
    input  wire logic [15:0]                   bus_din,      // host bus data in
    input  wire irc_pkg::irc_load_type         load,         // load strobes
    input  wire irc_pkg::irc_read_type         rsel,         // read selects
    input  wire logic                          int_en_set,   // set interrupt enable
    input  wire logic                          int_en_clr,   // clear interrupt enable
    input  wire logic                          fire,         // trigger command strobe
    input  wire logic                          preset_ones,  // reset preset select
    input  wire logic                          edge_fall,    // 1 = falling edge sets flag
    input  wire logic                          trig_neg,     // 1 = negative trigger
    input  wire logic [irc_pkg::PULSE_CNT_W-1:0] trig_width, // pulse width in cycles
    input  wire logic                          inst_ready,   // async ready from instrument
    input  wire logic [2:0]                    inst_status,  // overflow, remote, latch
    output logic [7:0]                         cable_byte,   // 8-bit register to cable
    output logic [15:0]                        cable_word,   // 16-bit register to cable
    output logic [15:0]                        bus_dout,     // read data to bus
    output logic                               bus_doe,      // bus drivers enabled
    output logic                               int_flag,     // interrupt flag
    output logic                               int_enable,   // interrupt enable flag
    output logic                               trig_out      // trigger pulse pin
);

    // ==========================================================
    // registers
    logic [7:0]  byte_q;
    logic [15:0] word_q;
    logic        first_q;
    logic        any_load;

    assign any_load = load.word_byte | load.word_lo | load.word_hi;

    // marks the first edge after release; the preset strap is applied there
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            first_q <= 1'b1;
        end else begin
            first_q <= 1'b0;
        end
    end

    // byte register loads and preset
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            byte_q <= irc_pkg::BYTE_PRESET_0;
        end else if (first_q) begin
            byte_q <= preset_ones ? irc_pkg::BYTE_PRESET_1
                                  : irc_pkg::BYTE_PRESET_0;
        end else if (load.word_byte) begin
            byte_q <= bus_din[7:0];
        end
    end

    // word register, one load lane per byte
    genvar g;
    generate
        for (g = 0; g < 2; g++) begin : g_lane
            logic lane_ld;
            assign lane_ld = (g == 0) ? load.word_lo : load.word_hi;
            always_ff @(posedge clk or posedge rst) begin
                if (rst) begin
                    word_q[g*8 +: 8] <= irc_pkg::WORD_PRESET_0[g*8 +: 8];
                end else if (first_q) begin
                    word_q[g*8 +: 8] <= preset_ones ? irc_pkg::WORD_PRESET_1[g*8 +: 8]
                                                    : irc_pkg::WORD_PRESET_0[g*8 +: 8];
                end else if (lane_ld) begin
                    word_q[g*8 +: 8] <= bus_din[g*8 +: 8];
                end
            end
        end
    endgenerate

    // cable copy of the byte register
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            cable_byte <= irc_pkg::BYTE_PRESET_0;
        end else begin
            cable_byte <= byte_q;
        end
    end

    // cable copy of the word register
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            cable_word <= irc_pkg::WORD_PRESET_0;
        end else begin
            cable_word <= word_q;
        end
    end

    // ==========================================================
    // ready synchroniser and edge detect
    logic sync1_q;
    logic sync2_q;
    logic sync3_q;
    logic ready_edge;

    // two-flop synchroniser for the asynchronous ready line
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            sync1_q <= 1'b0;
            sync2_q <= 1'b0;
        end else begin
            sync1_q <= inst_ready;
            sync2_q <= sync1_q;
        end
    end

    // history flop for edge detect, idles low like the line
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            sync3_q <= 1'b0;
        end else begin
            sync3_q <= sync2_q;
        end
    end

    assign ready_edge = edge_fall ? (sync3_q & ~sync2_q)
                                  : (~sync3_q & sync2_q);

    // interrupt flag: edge set wins over load clear
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            int_flag <= 1'b0;
        end else if (ready_edge) begin
            int_flag <= 1'b1;
        end else if (any_load) begin
            int_flag <= 1'b0;
        end
    end

    // interrupt enable, set under program control
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            int_enable <= 1'b0;
        end else if (int_en_set) begin
            int_enable <= 1'b1;
        end else if (int_en_clr) begin
            int_enable <= 1'b0;
        end
    end

    // ==========================================================
    // readback and status gates, wired-or of selected sources
    logic [15:0] rd_mux;

    always_comb begin
        rd_mux = 16'h0000;
        if (rsel.rd_byte) begin
            rd_mux = rd_mux | {8'h00, byte_q};
        end
        if (rsel.rd_word) begin
            rd_mux = rd_mux | word_q;
        end
        if (rsel.rd_status) begin
            rd_mux[irc_pkg::ST_FLAG_POS] = rd_mux[irc_pkg::ST_FLAG_POS] | int_flag;
            rd_mux[irc_pkg::ST_EN_POS]   = rd_mux[irc_pkg::ST_EN_POS] | int_enable;
            rd_mux[irc_pkg::ST_INST_POS +: irc_pkg::ST_INST_W] =
                rd_mux[irc_pkg::ST_INST_POS +: irc_pkg::ST_INST_W] | inst_status;
        end
    end

    // registered read data, zero when nothing is selected
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            bus_dout <= 16'h0000;
        end else begin
            bus_dout <= rd_mux;
        end
    end

    // bus driver enable, high while any select is held
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            bus_doe <= 1'b0;
        end else begin
            bus_doe <= rsel.rd_byte | rsel.rd_word | rsel.rd_status;
        end
    end

    // ==========================================================
    // trigger one-shot, width held inside the legal window
    logic [irc_pkg::PULSE_CNT_W-1:0] width_lim;

    always_comb begin
        width_lim = trig_width;
        if (trig_width < irc_pkg::PULSE_CNT_W'(irc_pkg::PULSE_MIN_CYC)) begin
            width_lim = irc_pkg::PULSE_CNT_W'(irc_pkg::PULSE_MIN_CYC);
        end else if (trig_width > irc_pkg::PULSE_CNT_W'(irc_pkg::PULSE_MAX_CYC)) begin
            width_lim = irc_pkg::PULSE_CNT_W'(irc_pkg::PULSE_MAX_CYC);
        end
    end

    irc_trigger u_trig (
        .clk       (clk),
        .rst       (rst),
        .fire      (fire),
        .width_cyc (width_lim),
        .neg_pol   (trig_neg),
        .trig_out  (trig_out)
    );

endmodule

`default_nettype wire

// *** sim/irc_port_asserts.sv ***
`timescale 1ns/1ps
`default_nettype none
module irc_port_asserts (
    input wire logic                  clk,         // clock
    input wire logic                  rst,         // reset
    input wire logic [15:0]           bus_din,     // bus data
    input wire irc_pkg::irc_load_type load,        // strobes
    input wire irc_pkg::irc_read_type rsel,        // selects
    input wire logic                  int_en_set,  // enable set
    input wire logic                  edge_fall,   // edge pick
    input wire logic                  inst_ready,  // ready
    input wire logic [2:0]            inst_status, // status
    input wire logic [7:0]            cable_byte,  // cable
    input wire logic [15:0]           cable_word,  // cable
    input wire logic [15:0]           bus_dout,    // read data
    input wire logic                  bus_doe,     // driver on
    input wire logic                  int_flag,    // flag
    input wire logic                  int_enable   // enable
);
    // ==========================================================
    // loads, reads and flags
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);
    sequence s_lo_load;
        load.word_lo && !$past(rst);
    endsequence
    sequence s_ready_rise;
        !edge_fall && $rose(inst_ready);
    endsequence
    a_lane_load: assert property (s_lo_load |=>
        ##1 cable_word[7:0] == $past(bus_din[7:0], 2)) else $error("lane not loaded");
    a_byte_load: assert property (load.word_byte && !$past(rst) |=>
        ##1 cable_byte == $past(bus_din[7:0], 2)) else $error("byte not loaded");
    a_word_read: assert property (rsel == 3'b010 |=> bus_doe && bus_dout == cable_word)
        else $error("word read wrong");
    a_byte_read: assert property (rsel == 3'b100 |=> bus_dout == {8'h00, cable_byte})
        else $error("byte read wrong");
    a_read_idle: assert property (rsel == 3'b000 |=> !bus_doe && bus_dout == 16'h0000)
        else $error("bus driven while idle");
    a_status_read: assert property (rsel == 3'b001 |=>
        bus_dout == {11'h000, $past(inst_status), $past(int_enable), $past(int_flag)})
        else $error("status word wrong");
    a_enable_set: assert property (int_en_set |=> int_enable) else $error("no enable");
    a_ready_flag: assert property (s_ready_rise |-> ##[1:5] int_flag)
        else $error("ready edge missed");
endmodule

bind irc_port irc_port_asserts irc_port_asserts_i (.clk, .rst, .bus_din, .load, .rsel,
    .int_en_set, .edge_fall, .inst_ready, .inst_status, .cable_byte, .cable_word,
    .bus_dout, .bus_doe, .int_flag, .int_enable);
`default_nettype wire

// *** sim/irc_inst_model.sv ***
`timescale 1ns/1ps
`default_nettype none
module irc_inst_model #(
    parameter logic [2:0] STATUS = 3'h5 // overflow, remote, latch
) (
    input  wire logic       go,          // ask for one ready pulse
    output logic            inst_ready,  // ready to device
    output logic [2:0]      inst_status  // status to device
);
    // status lines held steady
    assign inst_status = STATUS;
    // ready pulse off the clock grid
    initial inst_ready = 1'b0;
    always @(posedge go) begin
        #3.3 inst_ready = 1'b1;
        #200 inst_ready = 1'b0;
    end
endmodule
`default_nettype wire

// *** sim/testbench.sv ***
`timescale 1ns/1ps
`default_nettype none
module testbench;
    logic                  clk, rst, fire, go, preset_ones, edge_fall, trig_neg, int_en_set;
    logic                  int_en_clr, inst_ready, bus_doe, int_flag, int_enable, trig_out;
    logic [15:0]           bus_din, cable_word, bus_dout;
    logic [11:0]           trig_width;
    logic [7:0]            cable_byte;
    logic [2:0]            inst_status;
    irc_pkg::irc_load_type load;
    irc_pkg::irc_read_type rsel;
    int                    fails, checks_done, n;

    // ==========================================================
    // clock, device and instrument
    initial clk = 1'b0;
    always #2.5 clk = ~clk;
    irc_port irc_port_i (.clk, .rst, .bus_din, .load, .rsel, .int_en_set, .int_en_clr, .fire,
        .preset_ones, .edge_fall, .trig_neg, .trig_width, .inst_ready, .inst_status,
        .cable_byte, .cable_word, .bus_dout, .bus_doe, .int_flag, .int_enable, .trig_out);
    irc_inst_model irc_inst_model_i (.go, .inst_ready, .inst_status);

    // ==========================================================
    // compare and verdict
    task automatic chk(input string what, input logic [15:0] seen, input logic [15:0] exp);
        checks_done++;
        if (seen !== exp) begin
            fails++;
            $display("mismatch %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic finish_test;
        $display("checks %0d mismatches %0d", checks_done, fails);
        if (fails == 0 && checks_done > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask

    // ==========================================================
    // selector strobes and bounded waits
    task automatic ld(input irc_pkg::irc_load_type l, input logic [15:0] d);
        @(posedge clk);
        load    <= l;
        bus_din <= d;
        @(posedge clk);
        load <= 3'b000;
        repeat (2) @(posedge clk);
        @(negedge clk);
    endtask
    task automatic rd(input irc_pkg::irc_read_type r, input logic [15:0] exp, input string s);
        @(posedge clk);
        rsel <= r;
        @(negedge clk);
        @(negedge clk);
        chk(s, bus_dout, exp);
        chk("doe", {15'h0000, bus_doe}, 16'h0001);
        @(posedge clk);
        rsel <= 3'b000;
    endtask
    task automatic wait_flag;
        n = 0;
        while (int_flag !== 1'b1 && n < 80) begin
            n++;
            @(negedge clk);
        end
        chk("flag set", {15'h0000, int_flag}, 16'h0001);
        if (int_flag !== 1'b1) finish_test;
    endtask
    task automatic pulse(input logic [11:0] w, input logic [15:0] exp);
        @(posedge clk);
        trig_width <= w;
        fire       <= 1'b1;
        @(posedge clk);
        fire <= 1'b0;
        @(negedge clk);
        n = 0;
        while ((trig_out ^ trig_neg) !== 1'b1 && n < 4) begin
            n++;
            @(negedge clk);
        end
        n = 0;
        while ((trig_out ^ trig_neg) === 1'b1 && n < 3000) begin
            n++;
            @(negedge clk);
        end
        chk("pulse width", 16'(n), exp);
        if (n == 3000) finish_test;
    endtask

    // ==========================================================
    // test sequence
    initial begin
        {rst, fire, go, preset_ones, edge_fall, trig_neg, int_en_set, int_en_clr} = 8'h80;
        bus_din = 16'h0000;
        trig_width = 12'h1F4;
        load = 3'b000;
        rsel = 3'b000;
        fails = 0;
        checks_done = 0;
        repeat (10) @(posedge clk);
        rst <= 1'b0;
        repeat (3) @(negedge clk);
        chk("word preset", cable_word, 16'h0000);
        chk("flags reset", {14'h0000, int_flag, int_enable}, 16'h0000);
        $display("test reset done");
        ld(3'b011, 16'hA5C3);
        ld(3'b001, 16'h3C7E);
        chk("word cable", cable_word, 16'h3CC3);
        ld(3'b100, 16'hFF96);
        chk("byte cable", {8'h00, cable_byte}, 16'h0096);
        rd(3'b010, 16'h3CC3, "word read");
        rd(3'b100, 16'h0096, "byte read");
        $display("test registers done");
        @(posedge clk);
        int_en_set <= 1'b1;
        go         <= 1'b1;
        @(posedge clk);
        int_en_set <= 1'b0;
        go         <= 1'b0;
        wait_flag;
        rd(3'b001, 16'h0017, "status read");
        ld(3'b100, 16'h0096);
        chk("flag cleared", {15'h0000, int_flag}, 16'h0000);
        repeat (60) @(posedge clk);
        edge_fall <= 1'b1;
        go        <= 1'b1;
        repeat (20) @(negedge clk);
        chk("rise ignored", {15'h0000, int_flag}, 16'h0000);
        wait_flag;
        @(posedge clk);
        int_en_clr <= 1'b1;
        @(posedge clk);
        int_en_clr <= 1'b0;
        @(negedge clk);
        chk("enable cleared", {15'h0000, int_enable}, 16'h0000);
        @(posedge clk);
        int_en_set <= 1'b1;
        int_en_clr <= 1'b1;
        @(posedge clk);
        int_en_set <= 1'b0;
        int_en_clr <= 1'b0;
        @(negedge clk);
        chk("set beats clear", {15'h0000, int_enable}, 16'h0001);
        $display("test flags done");
        chk("idle low", {15'h0000, trig_out}, 16'h0000);
        pulse(12'h1F4, 16'h01F4);
        @(posedge clk);
        {rst, preset_ones, trig_neg, go} <= 4'hE;
        repeat (10) @(posedge clk);
        rst <= 1'b0;
        repeat (3) @(negedge clk);
        chk("word ones", cable_word, 16'hFFFF);
        chk("byte ones", {8'h00, cable_byte}, 16'h00FF);
        chk("flags cleared", {14'h0000, int_flag, int_enable}, 16'h0000);
        chk("idle high", {15'h0000, trig_out}, 16'h0001);
        pulse(12'h064, 16'h0190);
        $display("test trigger done");
        finish_test;
    end
endmodule
`default_nettype wire
